// ===== clmd_ctrl.sv
// Device control registers, reference routing and bank output gating
`timescale 1ns/1ns
`default_nettype none
module clmd_ctrl #(
  parameter int OUTS = 4
) (
  // Clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            srst_i,
  // Register port from the serial control engine
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [3:0]      reg_addr_i,
  input  wire logic [7:0]      reg_wdata_i,
  output logic      [7:0]      reg_rdata_o,
  // Reference clocks and pins, sampled as synchronous levels
  input  wire logic            reference_input_0_i,
  input  wire logic            reference_input_1_i,
  input  wire logic            ref_select_pin_i,
  input  wire logic            global_output_gate_i,
  // Bank A outputs
  output logic [OUTS-1:0]      bank_a_clk_o,
  output logic [OUTS-1:0]      bank_a_oe_o,
  // Bank B outputs
  output logic [OUTS-1:0]      bank_b_clk_o,
  output logic [OUTS-1:0]      bank_b_oe_o,
  // Analogue side controls
  output logic                 bank_a_supply_level_o,
  output logic                 bank_b_supply_level_o,
  output logic                 bank_a_power_off_o,
  output logic                 bank_b_power_off_o,
  output logic                 divider_a_power_off_o,
  output logic                 divider_b_power_off_o
);
  typedef struct packed {
    logic [15:0][7:0]  regs;
    logic [7:0]        rdata;
    logic              en_a;
    logic              en_b;
    logic [OUTS-1:0]   a_clk;
    logic [OUTS-1:0]   a_oe;
    logic [OUTS-1:0]   b_clk;
    logic [OUTS-1:0]   b_oe;
  } clmd_ctrl_state_t;

  clmd_ctrl_state_t st_r, st_nxt;

  // Decoded control fields
  logic                       switchover_style;
  logic [1:0]                 reference_choice;
  logic                       selection_source;
  logic                       divider_resync;
  logic                       bank_a_quiet_disable;
  logic                       bank_b_quiet_disable;
  logic                       bank_a_power_off;
  logic                       bank_b_power_off;
  logic [OUTS-1:0]            output_a_pair_disable;
  logic [OUTS-1:0]            output_b_pair_disable;
  logic [OUTS-1:0]            a_mode_live;
  logic [OUTS-1:0]            b_mode_live;
  logic [clmd_pkg::RATIO_W-1:0] divider_a_ratio;
  logic [clmd_pkg::RATIO_W-1:0] divider_b_ratio;
  logic [1:0]                 eff_choice;
  logic                       ref_a;
  logic                       ref_b;
  logic                       div_a;
  logic                       div_b;

  // Reset image of the whole register file
  function automatic logic [15:0][7:0] reset_image();
    logic [15:0][7:0] img;
    img = '0;
    img[clmd_pkg::OFF_A_MODE_HI] = clmd_pkg::RST_MODE_PAIR;
    img[clmd_pkg::OFF_A_MODE_LO] = clmd_pkg::RST_MODE_PAIR;
    img[clmd_pkg::OFF_B_MODE_HI] = clmd_pkg::RST_MODE_PAIR;
    img[clmd_pkg::OFF_B_MODE_LO] = clmd_pkg::RST_MODE_PAIR;
    return img;
  endfunction

  // True for the unimplemented offsets
  function automatic logic is_reserved(input logic [3:0] addr);
    return ((addr >= clmd_pkg::OFF_RSVD_FIRST) && (addr <= clmd_pkg::OFF_RSVD_LAST))
      || (addr == clmd_pkg::OFF_RSVD_TAIL);
  endfunction

  // Driver mode of pair m is live unless set to high impedance
  function automatic logic mode_live(input logic [15:0][7:0] r, input logic [3:0] hi,
                                     input logic [3:0] lo, input int m);
    logic [7:0] byte_v;
    logic [2:0] mode;
    byte_v = (m >= 2) ? r[hi] : r[lo];
    mode   = (m % 2 == 1) ? byte_v[clmd_pkg::MODE_W +: clmd_pkg::MODE_W]
                          : byte_v[0 +: clmd_pkg::MODE_W];
    return mode != clmd_pkg::MODE_HIZ;
  endfunction

  // Field extraction from the stored registers
  assign switchover_style     = st_r.regs[clmd_pkg::OFF_REF_SYNC][clmd_pkg::BIT_SWITCH_STYLE];
  assign reference_choice     = st_r.regs[clmd_pkg::OFF_REF_SYNC]
                                [clmd_pkg::BIT_CHOICE_HI:clmd_pkg::BIT_CHOICE_LO];
  assign selection_source     = st_r.regs[clmd_pkg::OFF_REF_SYNC][clmd_pkg::BIT_SEL_SOURCE];
  assign divider_resync       = st_r.regs[clmd_pkg::OFF_REF_SYNC][clmd_pkg::BIT_RESYNC];
  assign bank_a_quiet_disable = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_A_QUIET];
  assign bank_b_quiet_disable = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_B_QUIET];
  assign bank_a_power_off     = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_A_PWR_OFF];
  assign bank_b_power_off     = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_B_PWR_OFF];
  assign output_a_pair_disable = st_r.regs[clmd_pkg::OFF_A_DIS]
                                 [clmd_pkg::BIT_PAIR_DIS_LO +: OUTS];
  assign output_b_pair_disable = st_r.regs[clmd_pkg::OFF_B_DIS]
                                 [clmd_pkg::BIT_PAIR_DIS_LO +: OUTS];
  assign divider_a_ratio = {st_r.regs[clmd_pkg::OFF_DIV_HI][clmd_pkg::BIT_DIV_A_MSB],
                            st_r.regs[clmd_pkg::OFF_DIV_A_LO]};
  assign divider_b_ratio = {st_r.regs[clmd_pkg::OFF_DIV_HI][clmd_pkg::BIT_DIV_B_MSB],
                            st_r.regs[clmd_pkg::OFF_DIV_B_LO]};

  // Per-pair mode check for both banks
  always_comb begin
    for (int m = 0; m < OUTS; m++) begin
      a_mode_live[m] = mode_live(st_r.regs, clmd_pkg::OFF_A_MODE_HI,
                                 clmd_pkg::OFF_A_MODE_LO, m);
      b_mode_live[m] = mode_live(st_r.regs, clmd_pkg::OFF_B_MODE_HI,
                                 clmd_pkg::OFF_B_MODE_LO, m);
    end
  end

  // Pin drives both dividers from one reference; register bit splits them
  assign eff_choice = selection_source ? reference_choice
                                       : {ref_select_pin_i, ref_select_pin_i};

  // Reference selector per divider: low choice bit feeds A, high feeds B
  clmd_ref_switch u_sw_a (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .ref_0_i       (reference_input_0_i),
    .ref_1_i       (reference_input_1_i),
    .sel_i         (eff_choice[0]),
    .glitch_free_i (switchover_style),
    .ref_o         (ref_a)
  );

  clmd_ref_switch u_sw_b (
    .sys_clk_i     (sys_clk_i),
    .srst_i        (srst_i),
    .ref_0_i       (reference_input_0_i),
    .ref_1_i       (reference_input_1_i),
    .sel_i         (eff_choice[1]),
    .glitch_free_i (switchover_style),
    .ref_o         (ref_b)
  );

  // Both dividers share one resync level, so release lands on the same edge
  clmd_bank_div u_div_a (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .ref_i       (ref_a),
    .ratio_i     (divider_a_ratio),
    .hold_i      (divider_resync),
    .power_off_i (divider_a_power_off_o),
    .div_o       (div_a)
  );

  clmd_bank_div u_div_b (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .ref_i       (ref_b),
    .ratio_i     (divider_b_ratio),
    .hold_i      (divider_resync),
    .power_off_i (divider_b_power_off_o),
    .div_o       (div_b)
  );

  // Register access, enable synchronisers and output gating
  always_comb begin
    st_nxt = st_r;
    // Writes land directly; reserved offsets keep no storage
    if (reg_wr_i && !is_reserved(reg_addr_i)) begin
      st_nxt.regs[reg_addr_i] = reg_wdata_i;
    end
    // Reserved bits and offsets read as zero, which is one legal undefined value
    if (reg_rd_i) begin
      st_nxt.rdata = st_r.regs[reg_addr_i] & clmd_pkg::RD_MASK[reg_addr_i];
    end
    // Bank enables only move while the bank clock is low, so no runt pulse
    if (!div_a) begin
      st_nxt.en_a = !bank_a_quiet_disable && global_output_gate_i;
    end
    if (!div_b) begin
      st_nxt.en_b = !bank_b_quiet_disable && global_output_gate_i;
    end
    // Pair bits act at once; runts there are the host's concern
    for (int m = 0; m < OUTS; m++) begin
      st_nxt.a_oe[m]  = global_output_gate_i && st_r.en_a && !output_a_pair_disable[m]
                        && !bank_a_power_off && a_mode_live[m];
      st_nxt.b_oe[m]  = global_output_gate_i && st_r.en_b && !output_b_pair_disable[m]
                        && !bank_b_power_off && b_mode_live[m];
      st_nxt.a_clk[m] = div_a && st_r.en_a && !output_a_pair_disable[m] && !bank_a_power_off;
      st_nxt.b_clk[m] = div_b && st_r.en_b && !output_b_pair_disable[m] && !bank_b_power_off;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r      <= '0;
      st_r.regs <= reset_image();
      st_r.en_a <= 1'b1;
      st_r.en_b <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all straight from flip-flops
  assign reg_rdata_o           = st_r.rdata;
  assign bank_a_clk_o          = st_r.a_clk;
  assign bank_a_oe_o           = st_r.a_oe;
  assign bank_b_clk_o          = st_r.b_clk;
  assign bank_b_oe_o           = st_r.b_oe;
  assign bank_a_supply_level_o = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_A_SUPPLY];
  assign bank_b_supply_level_o = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_B_SUPPLY];
  assign bank_a_power_off_o    = bank_a_power_off;
  assign bank_b_power_off_o    = bank_b_power_off;
  assign divider_a_power_off_o = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_A_DIV_OFF];
  assign divider_b_power_off_o = st_r.regs[clmd_pkg::OFF_BANK_PWR][clmd_pkg::BIT_B_DIV_OFF];

  property p_reserved_reads_zero;
    @(posedge sys_clk_i) disable iff (srst_i)
      reg_rd_i && is_reserved(reg_addr_i) |=> reg_rdata_o == 8'h00;
  endproperty
  a_reserved_reads_zero: assert property (p_reserved_reads_zero) else $error("reserved read");

  property p_ctrl_readback;
    @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == clmd_pkg::OFF_REF_SYNC ##1 !reg_wr_i ##1
      reg_rd_i && reg_addr_i == clmd_pkg::OFF_REF_SYNC && !reg_wr_i
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & clmd_pkg::RD_MASK[clmd_pkg::OFF_REF_SYNC]);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback");

  property p_pin_source;
    @(posedge sys_clk_i) disable iff (srst_i)
      !selection_source && !switchover_style |=> ref_b == ref_a && ref_a ==
        ($past(ref_select_pin_i) ? $past(reference_input_1_i)
                                 : $past(reference_input_0_i));
  endproperty
  a_pin_source: assert property (p_pin_source) else $error("pin not steering mux");

  property p_choice_route;
    @(posedge sys_clk_i) disable iff (srst_i)
      selection_source && reference_choice == 2'h1 && !switchover_style
      |=> ref_a == $past(reference_input_1_i) && ref_b == $past(reference_input_0_i);
  endproperty
  a_choice_route: assert property (p_choice_route) else $error("choice 01 misrouted");

  property p_resync_halts;
    @(posedge sys_clk_i) disable iff (srst_i)
      divider_resync [*4] |-> bank_a_clk_o == '0 && bank_b_clk_o == '0;
  endproperty
  a_resync_halts: assert property (p_resync_halts) else $error("clock during resync");

  property p_gate_low_hiz;
    @(posedge sys_clk_i) disable iff (srst_i)
      !global_output_gate_i |=> bank_a_oe_o == '0 && bank_b_oe_o == '0;
  endproperty
  a_gate_low_hiz: assert property (p_gate_low_hiz) else $error("output on with gate low");

  property p_power_off_hiz;
    @(posedge sys_clk_i) disable iff (srst_i)
      bank_a_power_off ##1 bank_a_power_off |-> bank_a_oe_o == '0 && bank_a_clk_o == '0;
  endproperty
  a_power_off_hiz: assert property (p_power_off_hiz) else $error("bank A on while off");

  property p_quiet_low_phase;
    @(posedge sys_clk_i) disable iff (srst_i)
      $changed(st_r.en_a) |-> !$past(div_a);
  endproperty
  a_quiet_low_phase: assert property (p_quiet_low_phase) else $error("enable moved high");

  property p_supply_level;
    @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && reg_addr_i == clmd_pkg::OFF_BANK_PWR
      |=> bank_b_supply_level_o == $past(reg_wdata_i[clmd_pkg::BIT_B_SUPPLY]);
  endproperty
  a_supply_level: assert property (p_supply_level) else $error("supply level not stored");

  property p_choice_swap;
    @(posedge sys_clk_i) disable iff (srst_i)
      selection_source && reference_choice == 2'h2 && !switchover_style
      |=> ref_a == $past(reference_input_0_i) && ref_b == $past(reference_input_1_i);
  endproperty
  a_choice_swap: assert property (p_choice_swap) else $error("choice 10 misrouted");

  property p_write_lands;
    @(posedge sys_clk_i) disable iff (srst_i)
      reg_wr_i && !is_reserved(reg_addr_i)
      |=> st_r.regs[$past(reg_addr_i)] == $past(reg_wdata_i);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_pair_off_a;
    @(posedge sys_clk_i) disable iff (srst_i)
      output_a_pair_disable != '0
      |=> ((bank_a_oe_o | bank_a_clk_o) & $past(output_a_pair_disable)) == '0;
  endproperty
  a_pair_off_a: assert property (p_pair_off_a) else $error("disabled A pair active");

  property p_pair_off_b;
    @(posedge sys_clk_i) disable iff (srst_i)
      output_b_pair_disable != '0
      |=> ((bank_b_oe_o | bank_b_clk_o) & $past(output_b_pair_disable)) == '0;
  endproperty
  a_pair_off_b: assert property (p_pair_off_b) else $error("disabled B pair active");

  property p_quiet_low_phase_b;
    @(posedge sys_clk_i) disable iff (srst_i)
      $changed(st_r.en_b) |-> !$past(div_b);
  endproperty
  a_quiet_low_phase_b: assert property (p_quiet_low_phase_b) else $error("B enable moved high");

  property p_power_off_hiz_b;
    @(posedge sys_clk_i) disable iff (srst_i)
      bank_b_power_off ##1 bank_b_power_off |-> bank_b_oe_o == '0 && bank_b_clk_o == '0;
  endproperty
  a_power_off_hiz_b: assert property (p_power_off_hiz_b) else $error("bank B on while off");

  // Bypass still passes the reference, so only real ratios must go quiet
  property p_div_off_a;
    @(posedge sys_clk_i) disable iff (srst_i)
      divider_a_power_off_o && !divider_resync && divider_a_ratio >= clmd_pkg::RATIO_MIN_DIV
      |=> !div_a;
  endproperty
  a_div_off_a: assert property (p_div_off_a) else $error("divider A runs while off");

  property p_div_off_b;
    @(posedge sys_clk_i) disable iff (srst_i)
      divider_b_power_off_o && !divider_resync && divider_b_ratio >= clmd_pkg::RATIO_MIN_DIV
      |=> !div_b;
  endproperty
  a_div_off_b: assert property (p_div_off_b) else $error("divider B runs while off");
endmodule
`default_nettype wire

// ===== clmd_pkg.sv
// Constants for the clock mux and divider control block
package clmd_pkg;
  // Register offsets
  localparam logic [3:0] OFF_REF_SYNC   = 4'h0;
  localparam logic [3:0] OFF_BANK_PWR   = 4'h1;
  localparam logic [3:0] OFF_A_FIRST    = 4'h2;
  localparam logic [3:0] OFF_A_MODE_HI  = 4'h3;
  localparam logic [3:0] OFF_A_MODE_LO  = 4'h4;
  localparam logic [3:0] OFF_A_DIS      = 4'h5;
  localparam logic [3:0] OFF_B_MODE_HI  = 4'h7;
  localparam logic [3:0] OFF_B_MODE_LO  = 4'h8;
  localparam logic [3:0] OFF_B_DIS      = 4'h9;
  localparam logic [3:0] OFF_RSVD_FIRST = 4'ha;
  localparam logic [3:0] OFF_RSVD_LAST  = 4'hb;
  localparam logic [3:0] OFF_DIV_A_LO   = 4'hc;
  localparam logic [3:0] OFF_DIV_B_LO   = 4'hd;
  localparam logic [3:0] OFF_DIV_HI     = 4'he;
  localparam logic [3:0] OFF_RSVD_TAIL  = 4'hf;
  // Fields of the reference and sync control register
  localparam int BIT_SWITCH_STYLE = 7;
  localparam int BIT_CHOICE_HI    = 6;
  localparam int BIT_CHOICE_LO    = 5;
  localparam int BIT_SEL_SOURCE   = 4;
  localparam int BIT_RESYNC       = 0;
  // Fields of the bank power and enable register
  localparam int BIT_A_SUPPLY     = 7;
  localparam int BIT_B_SUPPLY     = 6;
  localparam int BIT_A_QUIET      = 5;
  localparam int BIT_B_QUIET      = 4;
  localparam int BIT_A_PWR_OFF    = 3;
  localparam int BIT_B_PWR_OFF    = 2;
  localparam int BIT_A_DIV_OFF    = 1;
  localparam int BIT_B_DIV_OFF    = 0;
  // Pair disable bits sit in the top nibble; ratio bit 8 pair in high register
  localparam int BIT_PAIR_DIS_LO  = 4;
  localparam int BIT_DIV_A_MSB    = 0;
  localparam int BIT_DIV_B_MSB    = 1;
  localparam int MODE_W           = 3;
  localparam logic [2:0] MODE_HIZ = 3'h0;
  // Reset values: every driver in differential mode, dividers bypassed
  localparam logic [7:0] RST_MODE_PAIR = 8'h12;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  // Bits that read back; reserved bits read as zero
  localparam logic [15:0][7:0] RD_MASK = {8'h00, 8'h03, 8'hff, 8'hff, 8'h00, 8'h00,
    8'hf0, 8'h3f, 8'h3f, 8'h10, 8'hf0, 8'h3f, 8'h3f, 8'h1f, 8'hff, 8'hf1};
  localparam int RATIO_W  = 9;
  localparam logic [8:0] RATIO_MIN_DIV = 9'h002;
endpackage

// ===== clmd_ref_switch.sv
// Reference selector with forced or glitch-free switchover
`timescale 1ns/1ns
`default_nettype none
module clmd_ref_switch (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  // References and selection
  input  wire logic ref_0_i,
  input  wire logic ref_1_i,
  input  wire logic sel_i,
  input  wire logic glitch_free_i,
  // Selected reference
  output logic      ref_o
);
  typedef struct packed {
    logic cur;
    logic on;
    logic out;
  } clmd_sw_state_t;

  clmd_sw_state_t st_r, st_nxt;
  logic           old_lvl, new_lvl;

  // Levels of the reference in use and of the wanted one
  assign old_lvl = st_r.cur ? ref_1_i : ref_0_i;
  assign new_lvl = sel_i ? ref_1_i : ref_0_i;

  // Switchover sequencing
  always_comb begin
    st_nxt = st_r;
    if (!glitch_free_i) begin
      st_nxt.cur = sel_i;
      st_nxt.on  = 1'b1;
      st_nxt.out = new_lvl;
    end else begin
      // An old reference stopped high parks us on it, as accepted
      if (st_r.on && (sel_i != st_r.cur) && !old_lvl) begin
        st_nxt.on  = 1'b0;
        st_nxt.cur = sel_i;
      end else if (!st_r.on && !old_lvl) begin
        st_nxt.on = 1'b1;
      end
      st_nxt.out = st_nxt.on & (st_nxt.cur ? ref_1_i : ref_0_i);
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ref_o = st_r.out;

  property p_forced_follows;
    @(posedge sys_clk_i) disable iff (srst_i)
      !glitch_free_i |=> ref_o == $past(new_lvl);
  endproperty
  a_forced_follows: assert property (p_forced_follows) else $error("forced switch lag");

  property p_gap_on_switch;
    @(posedge sys_clk_i) disable iff (srst_i)
      glitch_free_i && $past(glitch_free_i) && $changed(st_r.cur) |-> !st_r.on && !ref_o;
  endproperty
  a_gap_on_switch: assert property (p_gap_on_switch) else $error("switch without low gap");
endmodule
`default_nettype wire

// ===== clmd_bank_div.sv
// Bank divider with bypass, hold and power-down
`timescale 1ns/1ns
`default_nettype none
module clmd_bank_div #(
  parameter int RATIO_W = clmd_pkg::RATIO_W
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               srst_i,
  // Control
  input  wire logic               ref_i,
  input  wire logic [RATIO_W-1:0] ratio_i,
  input  wire logic               hold_i,
  input  wire logic               power_off_i,
  // Divided clock
  output logic                    div_o
);
  typedef struct packed {
    logic               prev;
    logic [RATIO_W-1:0] cnt;
    logic               out;
  } clmd_div_state_t;

  clmd_div_state_t st_r, st_nxt;
  logic            bypass;

  assign bypass = ratio_i < clmd_pkg::RATIO_MIN_DIV;

  // Count reference rising edges; high for the first half of each period
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = ref_i;
    if (hold_i) begin
      // Primed so the first edge after release starts a period
      st_nxt.cnt = ratio_i - RATIO_W'(1);
      st_nxt.out = 1'b0;
    end else if (bypass) begin
      st_nxt.cnt = '0;
      st_nxt.out = ref_i;
    end else if (power_off_i) begin
      st_nxt.cnt = '0;
      st_nxt.out = 1'b0;
    end else if (ref_i && !st_r.prev) begin
      st_nxt.cnt = (st_r.cnt >= ratio_i - RATIO_W'(1)) ? '0 : st_r.cnt + RATIO_W'(1);
      st_nxt.out = st_nxt.cnt < (ratio_i >> 1);
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign div_o = st_r.out;

  property p_bypass_passes;
    @(posedge sys_clk_i) disable iff (srst_i)
      bypass && !hold_i |=> div_o == $past(ref_i);
  endproperty
  a_bypass_passes: assert property (p_bypass_passes) else $error("bypass not passing");

  property p_hold_halts;
    @(posedge sys_clk_i) disable iff (srst_i)
      hold_i |=> !div_o;
  endproperty
  a_hold_halts: assert property (p_hold_halts) else $error("held divider toggles");
endmodule
`default_nettype wire

// ===== clmd_host.sv
// Host model driving the register port of the control block
`timescale 1ns/1ns
`default_nettype none
module clmd_host (
  // Clock
  input  wire logic       sys_clk_i,
  // Register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [3:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Idle port from time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 4'h0;
    reg_wdata_o = 8'h00;
  end
  // One strobe per byte; reserved bits forced to zero before sending
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d & clmd_pkg::RD_MASK[a];
    @(posedge sys_clk_i);
    reg_wr_o    <= 1'b0;
  endtask
  // Data lands one cycle after the read edge, taken mid-cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge sys_clk_i);
    reg_rd_o   <= 1'b0;
    @(negedge sys_clk_i);
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== clmd_ctrl_test.sv
// Self-checking testbench for the clock mux and divider control block
`timescale 1ns/1ns
`default_nettype none
module clmd_ctrl_test;
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic        ref0      = 1'b0;
  logic        ref1      = 1'b0;
  logic        pin       = 1'b0;
  logic        gate      = 1'b1;
  logic        reg_wr, reg_rd;
  logic [3:0]  reg_addr, a_clk, a_oe, b_clk, b_oe;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [7:0]  ref_cnt   = 8'h00;
  logic [5:0]  lvl;
  logic [15:0] ca, cb, cd;
  int          fail_count = 0;
  int          num_checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  // Periods of 8 and 12 cycles; a 96-cycle window holds whole periods
  always @(posedge sys_clk_i) begin
    ref_cnt <= (ref_cnt == 8'h17) ? 8'h00 : ref_cnt + 8'h01;
    ref0    <= ref_cnt[2];
    ref1    <= (ref_cnt >= 8'h06 && ref_cnt < 8'h0c) || ref_cnt >= 8'h12;
  end

  clmd_host i_clmd_host (
    .sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  clmd_ctrl #(.OUTS(4)) i_clmd_ctrl (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reference_input_0_i(ref0), .reference_input_1_i(ref1),
    .ref_select_pin_i(pin), .global_output_gate_i(gate),
    .bank_a_clk_o(a_clk), .bank_a_oe_o(a_oe), .bank_b_clk_o(b_clk), .bank_b_oe_o(b_oe),
    .bank_a_supply_level_o(lvl[5]), .bank_b_supply_level_o(lvl[4]),
    .bank_a_power_off_o(lvl[3]), .bank_b_power_off_o(lvl[2]),
    .divider_a_power_off_o(lvl[1]), .divider_b_power_off_o(lvl[0]));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Settle, then count rising edges of A output 1 and B output 0, and A/B differences
  // A output 0 gets pair-disabled late in the run, so it cannot be the probe
  task automatic count();
    logic pa, pb;
    ca = 16'h0;
    cb = 16'h0;
    cd = 16'h0;
    repeat (48) @(negedge sys_clk_i);
    pa = a_clk[1];
    pb = b_clk[0];
    repeat (96) begin
      @(negedge sys_clk_i);
      ca += {15'h0, a_clk[1] & ~pa};
      cb += {15'h0, b_clk[0] & ~pb};
      cd += {15'h0, a_clk[1] !== b_clk[0]};
      pa = a_clk[1];
      pb = b_clk[0];
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_clmd_host.wr(a, v);
  endtask

  // Wait long enough for enables to pass a low clock phase
  task automatic oe_is(input logic [7:0] exp);
    repeat (40) @(negedge sys_clk_i);
    check({8'h0, a_oe, b_oe}, {8'h0, exp});
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Reset map: mode registers differential, rest zero
    for (int i = 0; i < 16; i++) begin
      i_clmd_host.rd(i[3:0], d);
      check({8'h0, d}, (i == 3 || i == 4 || i == 7 || i == 8) ? 16'h0012 : 16'h0000);
    end
    oe_is(8'hff);
    check({10'h0, lvl}, 16'h0000);
    count();
    check(ca, 16'd12);
    check(cb, 16'd12);
    @(posedge sys_clk_i) pin <= 1'b1;
    count();
    check(ca + cb, 16'd16);
    // Every register choice; pin left high to show it is ignored
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {1'b0, c[1:0], 5'h10});
      i_clmd_host.rd(4'h0, d);
      check({8'h0, d}, {8'h0, 1'b0, c[1:0], 5'h10});
      count();
      check(ca, c[0] ? 16'd8 : 16'd12);
      check(cb, c[1] ? 16'd8 : 16'd12);
    end
    // Glitch-free switchover with both references alive
    wr(4'h0, 8'h90);
    wr(4'h0, 8'hf0);
    count();
    check(ca + cb, 16'd16);
    // Divide both banks by 4, then hold and release together
    wr(4'h0, 8'h10);
    wr(4'hc, 8'h04);
    wr(4'hd, 8'h04);
    count();
    check(ca + cb, 16'd6);
    wr(4'h0, 8'h11);
    count();
    check(ca + cb, 16'd0);
    wr(4'h0, 8'h10);
    count();
    check(cd, 16'd0);
    check(ca, 16'd3);
    // Quiet disable per bank, pair bits applied on release
    wr(4'h1, 8'h20);
    oe_is(8'h0f);
    wr(4'h5, 8'h50);
    wr(4'h9, 8'hc0);
    wr(4'h8, 8'h02);
    wr(4'h1, 8'h10);
    oe_is(8'ha0);
    wr(4'h1, 8'h00);
    oe_is(8'ha1);
    @(posedge sys_clk_i) gate <= 1'b0;
    oe_is(8'h00);
    @(posedge sys_clk_i) gate <= 1'b1;
    // Power-off sequences keep the bank quiet while powering back up
    wr(4'h1, 8'h3c);
    @(negedge sys_clk_i);
    check({10'h0, lvl}, 16'h000c);
    oe_is(8'h00);
    wr(4'h1, 8'h30);
    wr(4'h1, 8'h00);
    oe_is(8'ha1);
    // Dividers off, ratios back to zero for bypass
    wr(4'h1, 8'hc3);
    wr(4'hc, 8'h00);
    wr(4'hd, 8'h00);
    i_clmd_host.rd(4'h1, d);
    check({8'h0, d}, 16'h00c3);
    check({10'h0, lvl}, 16'h0033);
    count();
    check(ca + cb, 16'd24);
    // Mid-run reset, two edges long, restores the power-up map
    @(posedge sys_clk_i) srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    i_clmd_host.rd(4'h8, d);
    check({8'h0, d}, 16'h0012);
    check({10'h0, lvl}, 16'h0000);
    oe_is(8'hff);
    summarize();
  end
endmodule
`default_nettype wire
